// >>> rtl/ppt_cfg.svh
`ifndef PPT_CFG_SVH
`define PPT_CFG_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PPT_ADDR_MAIN_CTL1   32'h0262032C
`define PPT_ADDR_MEM_CTL1    32'h02620334
`define PPT_ADDR_PKT_CTL1    32'h0262033C
`define PPT_ADDR_MAIN_SEC    32'h02310108
`define PPT_ADDR_MAIN_RATIO  32'h02310110
`define PPT_ADDR_STATUS      32'h02310114
`define PPT_ADDR_RATE_INFO   32'h02310118

// ****************************************************************
// Field positions
// ****************************************************************
`define PPT_SAT_BIT          6
`define PPT_ODIV_LSB         19
`define PPT_ODIV_MSB         22
`define PPT_ODIV_DIV2        4'h1
`define PPT_MULT_LSB         0
`define PPT_DIV_LSB          16
`define PPT_BYPASS_BIT       31
`define PPT_LOOPS            3

// ****************************************************************
// Reset values
// ****************************************************************
`define PPT_CTL1_RST         32'h00000000
`define PPT_SEC_RST          32'h00000000
`define PPT_RATIO_RST        32'h80000000

// ****************************************************************
// Bus answers and timing
// ****************************************************************
`define PPT_RESP_OKAY        2'h0
`define PPT_RESP_SLVERR      2'h2
`define PPT_CLK_PERIOD_NS    40
`define PPT_LOCK_TIME_NS     50000
`define PPT_LOCK_CYCLES \
	((`PPT_LOCK_TIME_NS + `PPT_CLK_PERIOD_NS - 1) / `PPT_CLK_PERIOD_NS)

`endif

// >>> rtl/ppt_pkg.sv
package ppt_pkg;

	typedef logic [31:0] ppt_word_type;

	typedef struct packed {
		logic         wr;
		logic         rd;
		ppt_word_type waddr;
		ppt_word_type raddr;
		ppt_word_type wdata;
		logic [3:0]   wstrb;
	} ppt_reg_req_type;

	typedef struct packed {
		logic         wr_ok;
		logic         rd_ok;
		ppt_word_type rdata;
	} ppt_reg_rsp_type;

	typedef enum logic [1:0] {
		PPT_ST_SETTLE = 2'b01,
		PPT_ST_LOCKED = 2'b10
	} ppt_lock_state_type;

endpackage : ppt_pkg

// >>> rtl/ppt_axil_slave.sv
`timescale 1ns/100ps
`include "ppt_cfg.svh"

module ppt_axil_slave (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [31:0]              s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [31:0]              s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output ppt_pkg::ppt_reg_req_type      reg_req,
	input  wire ppt_pkg::ppt_reg_rsp_type reg_rsp
);
	import ppt_pkg::*;

	// ************************************************************
	// Write channels
	// ************************************************************
	logic         aw_held;
	logic         w_held;
	ppt_word_type awaddr_q;
	ppt_word_type wdata_q;
	logic [3:0]   wstrb_q;

	wire aw_take    = s_axi_awvalid & s_axi_awready;
	wire w_take     = s_axi_wvalid & s_axi_wready;
	// Fire only from held copies; costs a cycle, keeps muxing out
	wire do_write   = aw_held & w_held & ~s_axi_bvalid;
	wire next_aw_held = (aw_held & ~do_write) | aw_take;
	wire next_w_held  = (w_held & ~do_write) | w_take;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PPT_RESP_OKAY;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			s_axi_awready <= ~next_aw_held;
			s_axi_wready  <= ~next_w_held;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= reg_rsp.wr_ok ? `PPT_RESP_OKAY
				                              : `PPT_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (aw_take) begin
			awaddr_q <= s_axi_awaddr;
		end
		if (w_take) begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// ************************************************************
	// Read channels
	// ************************************************************
	wire ar_take      = s_axi_arvalid & s_axi_arready;
	wire next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PPT_RESP_OKAY;
		end else begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (ar_take) begin
				s_axi_rdata <= reg_rsp.rd_ok ? reg_rsp.rdata : 32'h00000000;
				s_axi_rresp <= reg_rsp.rd_ok ? `PPT_RESP_OKAY
				                             : `PPT_RESP_SLVERR;
			end
		end
	end

	assign reg_req.wr    = do_write;
	assign reg_req.rd    = ar_take;
	assign reg_req.waddr = awaddr_q;
	assign reg_req.raddr = s_axi_araddr;
	assign reg_req.wdata = wdata_q;
	assign reg_req.wstrb = wstrb_q;

endmodule : ppt_axil_slave

// >>> rtl/ppt_rate_gen.sv
`timescale 1ns/100ps

module ppt_rate_gen #(
	parameter int RATE_W = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              run,
	input  wire logic [RATE_W-1:0] numer,
	input  wire logic [RATE_W-1:0] denom,
	output logic                   tick
);
	// ************************************************************
	// Phase accumulator
	// ************************************************************
	// At most one tick per reference cycle: ratios above one clamp
	logic [RATE_W:0] acc;

	wire [RATE_W-1:0] num_eff  = (numer > denom) ? denom : numer;
	wire [RATE_W:0]   acc_sum  = acc + {1'b0, num_eff};
	wire              wrap     = (acc_sum >= {1'b0, denom});
	wire [RATE_W:0]   next_acc = wrap ? acc_sum - {1'b0, denom} : acc_sum;

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			acc  <= '0;
			tick <= 1'b0;
		end else begin
			acc  <= next_acc;
			tick <= wrap;
		end
	end

endmodule : ppt_rate_gen

// >>> rtl/ppt_pll_post_boot_tuning.sv
`timescale 1ns/100ps
`include "ppt_cfg.svh"

// Functional notes
// R1 - Software retunes main loop after boot
// R2 - Software sets saturation enable, all loops
// R3 - Saturation enable holds zero after boot
// R4 - Control-one registers at fixed loop addresses
// R5 - Read-modify-write keeps other bits intact
// R6 - Run loops near maximum frequency
// R7 - Main loop doubled, output divided by two
// R8 - Divider bits 22:19, code 0001 halves
// R9 - Output is ref times M+1 over 2(D+1)
// R10 - Downstream stays on bypass until relock; bypass_active follows ratio bit 31 one cycle after the write, and with it low ticks stay off until relock
module ppt_pll_post_boot_tuning #(
	parameter int MULT_W      = 8,
	parameter int DIV_W       = 6,
	parameter int RATE_W      = 16,
	parameter int LOCK_CYCLES = `PPT_LOCK_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output wire logic [2:0]  saturation_enable,
	output wire logic [2:0]  loop_locked,
	output logic [3:0]       main_output_divider,
	output logic             bypass_active,
	output logic             main_output_tick
);
	import ppt_pkg::*;

	localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
	localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic logic [2:0] loop_sel(input ppt_word_type a);
		loop_sel = {a == `PPT_ADDR_PKT_CTL1,
		            a == `PPT_ADDR_MEM_CTL1,
		            a == `PPT_ADDR_MAIN_CTL1};
	endfunction : loop_sel

	function automatic ppt_word_type merge(input ppt_word_type old_v,
	                                       input ppt_word_type new_v,
	                                       input logic [3:0]   strb);
		ppt_word_type m;
		m = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		merge = m;
	endfunction : merge

	// ************************************************************
	// Bus slave
	// ************************************************************
	ppt_reg_req_type req;
	ppt_reg_rsp_type rsp;

	ppt_axil_slave u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.reg_req       (req),
		.reg_rsp       (rsp)
	);

	// ************************************************************
	// Address decode
	// ************************************************************
	ppt_word_type ctl1 [`PPT_LOOPS];
	ppt_word_type main_pll_secondary_control;
	ppt_word_type main_pll_ratio;

	wire [2:0] wr_sel    = loop_sel(req.waddr); // [R4]
	wire [2:0] rd_sel    = loop_sel(req.raddr); // [R4]
	wire       wr_sec    = (req.waddr == `PPT_ADDR_MAIN_SEC); // [R8]
	wire       wr_ratio  = (req.waddr == `PPT_ADDR_MAIN_RATIO);
	wire       rd_sec    = (req.raddr == `PPT_ADDR_MAIN_SEC);
	wire       rd_ratio  = (req.raddr == `PPT_ADDR_MAIN_RATIO);
	wire       rd_status = (req.raddr == `PPT_ADDR_STATUS);
	wire       rd_info   = (req.raddr == `PPT_ADDR_RATE_INFO);
	wire       touch_main = req.wr & (wr_sec | wr_ratio);

	// ************************************************************
	// Main loop settings
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_pll_secondary_control <= `PPT_SEC_RST;
			main_pll_ratio             <= `PPT_RATIO_RST;
		end else begin
			if (req.wr && wr_sec) begin
				main_pll_secondary_control <= merge(
					main_pll_secondary_control, req.wdata,
					req.wstrb); // [R8]
			end
			if (req.wr && wr_ratio) begin
				main_pll_ratio <= merge(main_pll_ratio, req.wdata,
				                        req.wstrb);
			end
		end
	end

	wire [3:0] odiv = main_pll_secondary_control[
		`PPT_ODIV_MSB:`PPT_ODIV_LSB]; // [R8]
	wire [MULT_W-1:0] loop_multiplier_field =
		main_pll_ratio[`PPT_MULT_LSB +: MULT_W];
	wire [DIV_W-1:0] loop_divider_field =
		main_pll_ratio[`PPT_DIV_LSB +: DIV_W];

	// ************************************************************
	// Output rate: ref * (M+1) / ((D+1) * (code+1))
	// ************************************************************
	// Code 0001 gives the divide-by-two of the tuned setting
	wire [RATE_W-1:0]   numer  = RATE_W'(loop_multiplier_field)
	                           + RATE_W'(1); // [R9]
	wire [RATE_W-1:0]   den_d  = RATE_W'(loop_divider_field)
	                           + RATE_W'(1);
	wire [RATE_W-1:0]   den_o  = RATE_W'(odiv) + RATE_W'(1); // [R8]
	wire [2*RATE_W-1:0] den_p  = den_d * den_o;
	wire [RATE_W-1:0]   denom  = den_p[RATE_W-1:0]; // [R9]
	wire                div2_on = (odiv == `PPT_ODIV_DIV2); // [R8]

	// ************************************************************
	// Per-loop control and relock timing
	// ************************************************************
	wire [2:0] lk;

	for (genvar i = 0; i < `PPT_LOOPS; i++) begin : g_loop
		localparam logic IS_MAIN = (i == 0);
		ppt_lock_state_type state;
		ppt_lock_state_type next_state;
		logic [LOCK_W-1:0]  cnt;
		logic               locked_q;

		// Any retune restarts the settle window of that loop
		wire touch = (req.wr & wr_sel[i]) | (IS_MAIN & touch_main);

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctl1[i] <= `PPT_CTL1_RST; // [R3]
			end else if (req.wr && wr_sel[i]) begin
				ctl1[i] <= merge(ctl1[i], req.wdata, req.wstrb);
			end
		end

		always_comb begin
			next_state = state;
			case (state)
				PPT_ST_SETTLE: begin
					if (!touch && cnt == LOCK_LAST) begin
						next_state = PPT_ST_LOCKED;
					end
				end
				PPT_ST_LOCKED: begin
					if (touch) begin
						next_state = PPT_ST_SETTLE;
					end
				end
				default: begin
					next_state = PPT_ST_SETTLE;
				end
			endcase
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				state    <= PPT_ST_SETTLE;
				cnt      <= '0;
				locked_q <= 1'b0;
			end else begin
				state    <= next_state;
				cnt      <= (touch || state == PPT_ST_LOCKED) ? '0
				          : cnt + LOCK_W'(1);
				locked_q <= (next_state == PPT_ST_LOCKED);
			end
		end

		assign lk[i]                = locked_q;
		assign saturation_enable[i] = ctl1[i][`PPT_SAT_BIT]; // [R3]
	end

	assign loop_locked = lk;

	// ************************************************************
	// Main output path
	// ************************************************************
	logic gen_tick;

	// Gated while unlocked so a settling loop never leaks out
	ppt_rate_gen #(
		.RATE_W (RATE_W)
	) u_rate (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (lk[0] & ~bypass_active), // [R10]
		.numer   (numer),
		.denom   (denom),
		.tick    (gen_tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bypass_active       <= 1'b1;
			main_output_divider <= 4'h0;
			main_output_tick    <= 1'b0;
		end else begin
			bypass_active       <= main_pll_ratio[`PPT_BYPASS_BIT];
			main_output_divider <= odiv; // [R8]
			main_output_tick    <= bypass_active | gen_tick; // [R10]
		end
	end

	// ************************************************************
	// Read data and answers
	// ************************************************************
	wire [31:0] rd_loop = ({32{rd_sel[0]}} & ctl1[0])
	                    | ({32{rd_sel[1]}} & ctl1[1])
	                    | ({32{rd_sel[2]}} & ctl1[2]);
	wire [31:0] status  = {27'h0000000, div2_on, bypass_active, lk};
	wire [31:0] info    = {denom[15:0], numer[15:0]};

	assign rsp.wr_ok = (|wr_sel) | wr_sec | wr_ratio;
	assign rsp.rd_ok = (|rd_sel) | rd_sec | rd_ratio | rd_status
	                 | rd_info;
	assign rsp.rdata = rd_loop
	                 | ({32{rd_sec}} & main_pll_secondary_control)
	                 | ({32{rd_ratio}} & main_pll_ratio)
	                 | ({32{rd_status}} & status)
	                 | ({32{rd_info}} & info);

endmodule : ppt_pll_post_boot_tuning

// >>> dv/ppt_pll_post_boot_tuning_asserts.sv
`timescale 1ns/100ps
// ****************************************************************
// Port checker
// ****************************************************************
module ppt_pll_post_boot_tuning_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [2:0]  saturation_enable,
	input wire logic [2:0]  loop_locked,
	input wire logic [3:0]  main_output_divider,
	input wire logic        bypass_active,
	input wire logic        main_output_tick
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_sat_boot_zero: assert property ($rose(aresetn) |->
		saturation_enable == 3'h0 && main_output_divider == 4'h0)
		else $error("saturation or divider not cleared by reset");
	a_sat_by_write: assert property ($changed(saturation_enable) |->
		s_axi_bvalid && !$past(s_axi_bvalid))
		else $error("saturation enable moved without a write");
	a_div_lags_write: assert property ($changed(main_output_divider) |->
		$past(s_axi_bvalid))
		else $error("output divider moved without a write");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read data late");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_unmapped_zero: assert property (s_axi_rvalid &&
		s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000)
		else $error("unmapped read returned data");
	// Three cycles: tick may lag the lock flag by two registered cycles
	a_tick_gated: assert property (
		(!loop_locked[0] && !bypass_active) [*3] |-> !main_output_tick)
		else $error("tick while main loop unlocked");
endmodule : ppt_pll_post_boot_tuning_asserts

bind ppt_pll_post_boot_tuning ppt_pll_post_boot_tuning_asserts u_chk (.*);

// >>> dv/tb_ppt_pll_post_boot_tuning.sv
`timescale 1ns/100ps
`include "ppt_cfg.svh"
// ****************************************************************
// Bench
// ****************************************************************
module tb_ppt_pll_post_boot_tuning;
	import ppt_pkg::*;
	logic         aclk;
	logic         aresetn;
	ppt_word_type s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]   s_axi_wstrb, main_output_divider;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready, bypass_active, main_output_tick;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic [2:0]   saturation_enable, loop_locked;
	int           fails = 0;
	int           cmp_count = 0;
	int           cycles = 0;
	int           ticks, exp_t;
	ppt_word_type rd;
	ppt_word_type ctl[3] = '{`PPT_ADDR_MAIN_CTL1, `PPT_ADDR_MEM_CTL1,
		`PPT_ADDR_PKT_CTL1};

	// Short lock count keeps the relock waits brief
	ppt_pll_post_boot_tuning #(.LOCK_CYCLES(8)) DUT (.*);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic chk(input ppt_word_type got, input ppt_word_type exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		if (fails == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fails++;
			complete_run();
		end
	end

	// ****************************************************************
	// Bus tasks; bready and rready stay high throughout
	// ****************************************************************
	task automatic axi_write(input ppt_word_type a, d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
	endtask : axi_write

	task automatic axi_read(input ppt_word_type a, output ppt_word_type d,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
	endtask : axi_read

	// Software read-modify-write, then read back against the bench value
	task automatic rmw(input ppt_word_type a, m, v, exp);
		ppt_word_type r;
		axi_read(a, r, `PPT_RESP_OKAY);
		axi_write(a, (r & ~m) | v, 4'hF, `PPT_RESP_OKAY);
		axi_read(a, r, `PPT_RESP_OKAY);
		chk(r, exp);
	endtask : rmw

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 32'h00000000;
		s_axi_wdata = 32'h00000000;
		s_axi_araddr = 32'h00000000;
		s_axi_wstrb = 4'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(saturation_enable, 32'h00000000);
		chk(bypass_active, 32'h00000001);
		for (int i = 0; i < 3; i++) begin
			axi_read(ctl[i], rd, `PPT_RESP_OKAY);
			chk(rd, `PPT_CTL1_RST);
			axi_write(ctl[i], 32'h00000A05, 4'hF, `PPT_RESP_OKAY);
			rmw(ctl[i], 32'h00000040, 32'h00000040, 32'h00000A45);
			chk(saturation_enable, (32'h1 << (i + 1)) - 1);
		end
		// Only the low byte lane is written
		axi_write(ctl[0], 32'h00000000, 4'h1, `PPT_RESP_OKAY);
		axi_read(ctl[0], rd, `PPT_RESP_OKAY);
		chk(rd, 32'h00000A00);
		chk(saturation_enable, 32'h00000006);
		axi_read(`PPT_ADDR_MAIN_SEC, rd, `PPT_RESP_OKAY);
		chk(rd, `PPT_SEC_RST);
		axi_write(`PPT_ADDR_MAIN_SEC, 32'h12345678, 4'hF, `PPT_RESP_OKAY);
		rmw(`PPT_ADDR_MAIN_SEC, 32'h00780000, 32'h00080000, 32'h120C5678);
		chk(main_output_divider, `PPT_ODIV_DIV2);
		axi_write(32'h02620330, 32'hFFFFFFFF, 4'hF, `PPT_RESP_SLVERR);
		axi_read(32'h02620330, rd, `PPT_RESP_SLVERR);
		chk(rd, 32'h00000000);
		// Divide by two in force: rate is (M+1) / (2 (D+1))
		for (int k = 0; k < 2; k++) begin
			axi_write(`PPT_ADDR_MAIN_RATIO, (k << 16) | (2 * k), 4'hF,
				`PPT_RESP_OKAY);
			repeat (3) @(posedge aclk);
			chk(bypass_active, 32'h00000000);
			while (loop_locked[0] !== 1'b1) @(posedge aclk);
			chk(loop_locked, 32'h00000007);
			ticks = 0;
			repeat (100) begin
				@(posedge aclk);
				ticks += main_output_tick;
			end
			exp_t = 100 * (2 * k + 1) / (2 * (k + 1));
			chk(ticks >= exp_t - 1 && ticks <= exp_t + 1, 32'h1);
		end
		complete_run();
	end
endmodule : tb_ppt_pll_post_boot_tuning
